// [hdl/pim_defines.vh]
// pim_defines.vh: offsets, widths and mode codes of the process image mapper.
// assumes: included by bare name by the mapper module; the fifo takes its sizes as parameters.
`ifndef PIM_DEFINES_VH
`define PIM_DEFINES_VH
// analog layout modes
`define PIM_MODE_PLAIN       2'h0
`define PIM_MODE_MAILBOX     2'h1
`define PIM_MODE_SINGLE      2'h2
// word offsets inside one analog module's image
`define PIM_WO_CH1           3'h0
`define PIM_WO_CH2           3'h1
`define PIM_WO_REF           3'h1
`define PIM_WO_STAT          3'h0
`define PIM_WO_MBX_FIRST     3'h1
`define PIM_WO_MBX_LAST      3'h3
`define PIM_WO_MBX_CH1       3'h4
`define PIM_WO_MBX_CH2       3'h5
// image sizes in words and bytes
`define PIM_WORDS_PLAIN      3'h2
`define PIM_WORDS_MAILBOX    3'h6
`define PIM_MBX_BYTES        4'h6
`define PIM_IMG_BYTES        4'hC
// fifo defaults
`define PIM_FIFO_DEPTH       8
`define PIM_FIFO_WIDTH       16
`endif

// [hdl/pim_fifo.v]
// pim_fifo.v: synchronous fifo carrying input image words to the controller.
// assumes: one clock, asynchronous active high reset, depth a power of two.
`timescale 1ns/1ps
`default_nettype none
module pim_fifo #(
    parameter WIDTH = 16,
    parameter DEPTH = 8,
    parameter AW    = 3
) (
    input  wire             clk_i,
    input  wire             sys_rst_i,
    input  wire             wr_valid_i,
    output wire             wr_ready_o,
    input  wire [WIDTH-1:0] wr_data_i,
    output wire             rd_valid_o,
    input  wire             rd_ready_i,
    output wire [WIDTH-1:0] rd_data_o
);
    reg [WIDTH-1:0] mem_q [0:DEPTH-1];
    reg [AW:0]      wr_ptr_q;
    reg [AW:0]      rd_ptr_q;
    wire            full;
    wire            empty;
    wire            push;
    wire            pop;

    // extra pointer bit tells full from empty
    assign full       = (wr_ptr_q[AW] != rd_ptr_q[AW]) && (wr_ptr_q[AW-1:0] == rd_ptr_q[AW-1:0]);
    assign empty      = (wr_ptr_q == rd_ptr_q);
    assign wr_ready_o = ~full;
    assign rd_valid_o = ~empty;
    assign push       = wr_valid_i & ~full;
    assign pop        = rd_ready_i & ~empty;
    assign rd_data_o  = mem_q[rd_ptr_q[AW-1:0]];

    // storage has no reset; only the pointers need a defined value
    always @(posedge clk_i)
    begin
        if (push)
        begin
            mem_q[wr_ptr_q[AW-1:0]] <= wr_data_i;
        end
    end

    // pointer update
    always @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            wr_ptr_q <= {(AW+1){1'b0}};
            rd_ptr_q <= {(AW+1){1'b0}};
        end
        else
        begin
            if (push)
            begin
                wr_ptr_q <= wr_ptr_q + 1'b1;
            end
            if (pop)
            begin
                rd_ptr_q <= rd_ptr_q + 1'b1;
            end
        end
    end
endmodule // pim_fifo
`default_nettype wire

// [hdl/pim_mapper.v]
// pim_mapper.v: maps digital and analog module data into process images.
// assumes: module pins and field values are synchronous to clk_i unless marked;
// the controller pulls input image words from a fifo and writes outputs by word.
`timescale 1ns/1ps
`default_nettype none
`include "pim_defines.vh"
module pim_mapper #(
    parameter FIFO_DEPTH = `PIM_FIFO_DEPTH,
    parameter FIFO_AW    = 3
) (
    input  wire        clk_i,
    input  wire        sys_rst_i,
    // scan trigger: one pulse builds one input image
    input  wire        scan_start_i,
    output wire        scan_busy_o,
    // analog module layout chosen at configuration
    input  wire [1:0]  ana_mode_i,
    input  wire [15:0] ana_ch1_value_i,
    input  wire [15:0] ana_ch2_value_i,
    input  wire [7:0]  ana_ch1_ctrl_stat_i,
    input  wire [7:0]  ana_ch2_ctrl_stat_i,
    input  wire [7:0]  module_status_byte_i,
    input  wire [47:0] mailbox_response_bytes_i,
    output reg  [7:0]  module_control_byte_o,
    output reg  [47:0] mailbox_request_bytes_o,
    // digital field pins (asynchronous)
    input  wire [7:0]  digital_input_channel_i,
    output reg  [15:0] do16_channel_o,
    output reg  [7:0]  do8_channel_o,
    // controller output image write, one word per strobe
    input  wire        out_wr_i,
    input  wire [3:0]  out_word_i,
    input  wire [15:0] out_data_i,
    // controller input image read stream
    output wire        in_valid_o,
    input  wire        in_ready_i,
    output wire [15:0] in_data_o,
    output wire        cfg_status_o
);
    localparam ST_IDLE = 3'b001;
    localparam ST_ANA  = 3'b010;
    localparam ST_DIG  = 3'b100;

    reg  [7:0]  di_meta_q;
    reg  [7:0]  di_sync_q;
    reg  [2:0]  state_q;
    reg  [2:0]  word_q;
    reg  [1:0]  mode_q;
    reg  [15:0] wr_word;
    wire        fifo_ready;
    wire        push;
    wire [2:0]  last_word;

    // little endian word: low byte first on the wire, high byte above
    function [15:0] le_word;
        input [7:0] lo;
        input [7:0] hi;
        begin
            le_word = {hi, lo};
        end
    endfunction

    // picks one 16-bit lane of the mailbox byte array
    function [15:0] mbx_word;
        input [47:0] bytes;
        input [2:0]  idx;
        begin
            case (idx)
                3'h1:    mbx_word = le_word(bytes[7:0],   bytes[15:8]);
                3'h2:    mbx_word = le_word(bytes[23:16], bytes[31:24]);
                default: mbx_word = le_word(bytes[39:32], bytes[47:40]);
            endcase
        end
    endfunction

    // two flip-flops before any logic sees the field inputs
    always @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            di_meta_q <= 8'h00;
            di_sync_q <= 8'h00;
        end
        else
        begin
            di_meta_q <= digital_input_channel_i;
            di_sync_q <= di_meta_q;
        end
    end

    // controller writes into the output image; outputs follow image bits
    always @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            do16_channel_o          <= 16'h0000;
            do8_channel_o           <= 8'h00;
            module_control_byte_o   <= 8'h00;
            mailbox_request_bytes_o <= 48'h000000000000;
        end
        else if (out_wr_i)
        begin
            case (out_word_i)
                // word 0 bytes 0/1 drive channels 1..8 and 9..16
                4'h0: do16_channel_o <= out_data_i;
                4'h1: do8_channel_o  <= out_data_i[7:0];
                // mailbox output image, only meaningful in mailbox mode
                4'h2: module_control_byte_o <= out_data_i[7:0];
                4'h3: mailbox_request_bytes_o[15:0]  <= out_data_i;
                4'h4: mailbox_request_bytes_o[31:16] <= out_data_i;
                4'h5: mailbox_request_bytes_o[47:32] <= out_data_i;
                default: ; // word addresses 6..15 are refused and change nothing
            endcase
        end
    end

    // last analog word of the image depends on layout
    assign last_word = (mode_q == `PIM_MODE_MAILBOX) ?
                       (`PIM_WORDS_MAILBOX - 3'h1) : (`PIM_WORDS_PLAIN - 3'h1);

    // input image word select; control/status bits are never routed here
    always @*
    begin
        wr_word = 16'h0000;
        case (state_q)
            ST_ANA:
            begin
                if (mode_q == `PIM_MODE_MAILBOX)
                begin
                    // status word first, then the mailbox, values after it
                    if (word_q == `PIM_WO_STAT)
                        wr_word = le_word(module_status_byte_i, 8'h00);
                    else if (word_q <= `PIM_WO_MBX_LAST)
                        wr_word = mbx_word(mailbox_response_bytes_i, word_q);
                    else if (word_q == `PIM_WO_MBX_CH1)
                        wr_word = le_word(ana_ch1_value_i[7:0], ana_ch1_value_i[15:8]);
                    else
                        wr_word = le_word(ana_ch2_value_i[7:0], ana_ch2_value_i[15:8]);
                end
                else if (word_q == `PIM_WO_CH1)
                    // value word, single or two channel alike
                    wr_word = le_word(ana_ch1_value_i[7:0], ana_ch1_value_i[15:8]);
                else
                    // second word: channel 2 or reference value
                    wr_word = le_word(ana_ch2_value_i[7:0], ana_ch2_value_i[15:8]);
            end
            ST_DIG:  wr_word = {8'h00, di_sync_q};
            default: wr_word = 16'h0000;
        endcase
    end

    assign push = (state_q != ST_IDLE) & fifo_ready;

    // scan sequencer: analog words first, then the digital byte
    always @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            state_q <= ST_IDLE;
            word_q  <= 3'h0;
            mode_q  <= `PIM_MODE_PLAIN;
        end
        else
        begin
            case (state_q)
                ST_IDLE:
                begin
                    if (scan_start_i)
                    begin
                        // mode latched per scan so one image never mixes layouts
                        mode_q  <= ana_mode_i;
                        word_q  <= 3'h0;
                        state_q <= ST_ANA;
                    end
                end
                ST_ANA:
                begin
                    if (push)
                    begin
                        if (word_q == last_word)
                            state_q <= ST_DIG;
                        else
                            word_q <= word_q + 3'h1;
                    end
                end
                ST_DIG:
                begin
                    if (push)
                        state_q <= ST_IDLE;
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // fifo back-pressure stalls the sequencer when the controller lags
    pim_fifo #(
        .WIDTH (`PIM_FIFO_WIDTH),
        .DEPTH (FIFO_DEPTH),
        .AW    (FIFO_AW)
    ) u_fifo (
        .clk_i      (clk_i),
        .sys_rst_i  (sys_rst_i),
        .wr_valid_i (state_q != ST_IDLE),
        .wr_ready_o (fifo_ready),
        .wr_data_i  (wr_word),
        .rd_valid_o (in_valid_o),
        .rd_ready_i (in_ready_i),
        .rd_data_o  (in_data_o)
    );

    assign scan_busy_o = (state_q != ST_IDLE);
    // control/status bits reach only this internal configuration flag
    assign cfg_status_o = |(ana_ch1_ctrl_stat_i & ana_ch2_ctrl_stat_i);
endmodule // pim_mapper
`default_nettype wire

// [tb/pim_mapper_props.sv]
// pim_mapper_props.sv: port assertions for the process image mapper.
// assumes: bound to pim_mapper; one clock, asynchronous active high reset.
`timescale 1ns/1ps
`default_nettype none
module pim_mapper_props (
    input wire logic        clk_i,
    input wire logic        sys_rst_i,
    input wire logic        scan_start_i,
    input wire logic        scan_busy_o,
    input wire logic        out_wr_i,
    input wire logic [3:0]  out_word_i,
    input wire logic [15:0] out_data_i,
    input wire logic [15:0] do16_channel_o,
    input wire logic [7:0]  do8_channel_o,
    input wire logic [7:0]  module_control_byte_o,
    input wire logic [47:0] mailbox_request_bytes_o,
    input wire logic        in_valid_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    // a write lands on its target the cycle after the strobe
    do16_map_a: assert property (out_wr_i && out_word_i == 4'h0
        |=> do16_channel_o == $past(out_data_i)) else $error("do16 write lost");
    do8_map_a: assert property (out_wr_i && out_word_i == 4'h1
        |=> do8_channel_o == $past(out_data_i[7:0])) else $error("do8 write lost");
    ctrl_byte_a: assert property (out_wr_i && out_word_i == 4'h2
        |=> module_control_byte_o == $past(out_data_i[7:0])) else $error("control byte");
    req_bytes_a: assert property (out_wr_i && out_word_i == 4'h4
        |=> mailbox_request_bytes_o[31:16] == $past(out_data_i)) else $error("request");
    // do16 and do8 only move on a write to word 0 or 1; writes to any other word leave both stable
    do_hold_a: assert property (!(out_wr_i && out_word_i < 4'h2)
        |=> $stable(do16_channel_o) && $stable(do8_channel_o)) else $error("output moved");
    scan_busy_a: assert property (scan_start_i && !scan_busy_o |=> scan_busy_o)
        else $error("scan not started");
    scan_first_a: assert property (scan_start_i && !scan_busy_o && !in_valid_o
        |=> ##1 in_valid_o) else $error("first word late");
    scan_end_a: assert property ($rose(scan_busy_o) |-> ##[1:300] !scan_busy_o)
        else $error("scan hung");
endmodule // pim_mapper_props
bind pim_mapper pim_mapper_props pim_mapper_props_inst (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .scan_start_i(scan_start_i),
    .scan_busy_o(scan_busy_o), .out_wr_i(out_wr_i), .out_word_i(out_word_i),
    .out_data_i(out_data_i), .do16_channel_o(do16_channel_o),
    .do8_channel_o(do8_channel_o), .module_control_byte_o(module_control_byte_o),
    .mailbox_request_bytes_o(mailbox_request_bytes_o), .in_valid_o(in_valid_o));
`default_nettype wire

// [tb/pim_ctrl_model.sv]
// pim_ctrl_model.sv: controller side pulling input image words.
// assumes: stall_i is moved by the bench 1 ns after a rising edge.
`timescale 1ns/1ps
`default_nettype none
module pim_ctrl_model (
    input  wire logic        clk_i,
    input  wire logic        stall_i,
    input  wire logic        valid_i,
    output var  logic        ready_o,
    input  wire logic [15:0] data_i
);
    logic [15:0] got [$];
    initial ready_o = 1'b0;
    // take a word where valid and ready meet; ready moves 1 ns after the edge like bench inputs
    always @(posedge clk_i)
    begin
        if (valid_i && ready_o)
            got.push_back(data_i);
        ready_o <= #1 !stall_i;
    end
endmodule // pim_ctrl_model
`default_nettype wire

// [tb/pim_mapper_tb_top.sv]
// pim_mapper_tb_top.sv: self-checking bench for the process image mapper.
// assumes: inputs move 1 ns after a rising edge of the 200 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module pim_mapper_tb_top;
    logic        clk_i = 1'b0, sys_rst_i = 1'b1, start_q = 1'b0, wr_q = 1'b0, stall = 1'b0;
    logic [1:0]  mode = 2'h0;
    logic [3:0]  word = 4'h0;
    logic [15:0] ch1 = 16'hB2A1, ch2 = 16'hD4C3, wdata = 16'h0;
    logic [7:0]  cs1 = 8'hFF, cs2 = 8'h5A, stat = 8'h3C, din = 8'h81;
    logic [47:0] resp = 48'h060504030201;
    wire  [15:0] do16, in_data;
    wire  [7:0]  do8, cbyte;
    wire  [47:0] req;
    wire         busy, in_valid, in_ready, cfg;
    int          bad_count = 0, num_checks = 0;
    always #2.5 clk_i = ~clk_i;
    pim_mapper pim_mapper_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .scan_start_i(start_q),
        .scan_busy_o(busy), .ana_mode_i(mode), .ana_ch1_value_i(ch1), .ana_ch2_value_i(ch2),
        .ana_ch1_ctrl_stat_i(cs1), .ana_ch2_ctrl_stat_i(cs2), .module_status_byte_i(stat),
        .mailbox_response_bytes_i(resp), .module_control_byte_o(cbyte),
        .mailbox_request_bytes_o(req), .digital_input_channel_i(din), .do16_channel_o(do16),
        .do8_channel_o(do8), .out_wr_i(wr_q), .out_word_i(word), .out_data_i(wdata),
        .in_valid_o(in_valid), .in_ready_i(in_ready), .in_data_o(in_data), .cfg_status_o(cfg));
    pim_ctrl_model pim_ctrl_model_inst (.clk_i(clk_i), .stall_i(stall), .valid_i(in_valid),
        .ready_o(in_ready), .data_i(in_data));
    // 64 bits so the control byte and all request bytes fit in one compare
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // one output image word write; the target moves at the taking edge
    task automatic wr(input logic [3:0] w, input logic [15:0] d);
        @(posedge clk_i);
        #1;
        wr_q = 1'b1;
        word = w;
        wdata = d;
        @(posedge clk_i);
        #1;
        wr_q = 1'b0;
    endtask
    task automatic start;
        @(posedge clk_i);
        #1;
        start_q = 1'b1;
        @(posedge clk_i);
        #1;
        start_q = 1'b0;
    endtask
    // one scan, then every pulled word against the expected image
    task automatic scan(input logic [1:0] m, input logic [15:0] e [$]);
        mode = m;
        start;
        for (int n = 0; n < 100 && (busy || pim_ctrl_model_inst.got.size() < e.size()); n++)
            @(posedge clk_i);
        #1;
        chk(pim_ctrl_model_inst.got.size(), e.size());
        foreach (e[i]) chk(pim_ctrl_model_inst.got[i], e[i]);
        pim_ctrl_model_inst.got.delete();
    endtask
    task automatic t_outputs;
        for (int i = 0; i < 16; i++)
        begin
            wr(4'h0, 16'h1 << i);
            chk(do16, 16'h1 << i);
        end
        wr(4'h1, 16'hFFA5);
        wr(4'h6, 16'h0);
        wr(4'hF, 16'h0);
        chk({do16, do8}, 24'h8000A5);
        wr(4'h2, 16'hEE5A);
        wr(4'h3, 16'h2211);
        wr(4'h4, 16'h4433);
        wr(4'h5, 16'h6655);
        chk({cbyte, req}, 56'h5A665544332211);
    endtask
    task automatic t_inputs;
        repeat (3) @(posedge clk_i);
        chk(cfg, 1'b1);
        scan(2'h0, '{16'hB2A1, 16'hD4C3, 16'h0081});
        scan(2'h2, '{16'hB2A1, 16'hD4C3, 16'h0081});
        scan(2'h1, '{16'h003C, 16'h0201, 16'h0403, 16'h0605,
            16'hB2A1, 16'hD4C3, 16'h0081});
        cs1 = 8'h00;
        cs2 = 8'hC3;
        scan(2'h3, '{16'hB2A1, 16'hD4C3, 16'h0081});
        chk(cfg, 1'b0);
    endtask
    // the controller stalls until the fifo is full, then drains it
    task automatic t_fill;
        stall = 1'b1;
        mode = 2'h0;
        repeat (3)
        begin
            start;
            for (int n = 0; n < 20 && busy; n++) @(posedge clk_i);
        end
        #1;
        chk({busy, in_valid}, 2'b11);
        stall = 1'b0;
        for (int n = 0; n < 40 && (busy || in_valid); n++) @(posedge clk_i);
        chk(pim_ctrl_model_inst.got.size(), 9);
        for (int n = 0; n < 9; n++)
            chk(pim_ctrl_model_inst.got[n], n % 3 == 2 ? 16'h0081 : (n % 3 ? ch2 : ch1));
    endtask
    // mid-run reset clears every registered output and empties the input stream
    task automatic t_reset;
        @(posedge clk_i);
        #1;
        sys_rst_i = 1'b1;
        @(posedge clk_i);
        #1;
        sys_rst_i = 1'b0;
        chk({do16, do8, cbyte}, 32'h0);
        chk(req, 48'h0);
        chk({busy, in_valid}, 2'b00);
    endtask
    task automatic end_sim;
        if (bad_count == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (4) @(posedge clk_i);
        #1;
        sys_rst_i = 1'b0;
        t_outputs;
        t_reset;
        t_inputs;
        t_fill;
        end_sim;
    end
    // watchdog well past the few hundred cycles the tests need
    initial
    begin
        #20000;
        bad_count++;
        end_sim;
    end
endmodule // pim_mapper_tb_top
`default_nettype wire
